// [logic/rro_map.vh]
// Constants, field layouts and register map of the relative-reference offset unit
// Notes on behaviour
// - Offset-null key press lights the relative indicator immediately, before any capture.
// - Next completed measurement becomes the reference, tagged with its function and range.
// - With a reference active, output is measured value minus reference, signed.
// - The measurement captured as reference is itself output as zero.
// - Key press again, power loss, or capture under another function cancels reference.
// - Range change within a function rescales reference by matching power of ten.
// - Function change clears indicator, stops subtracting, keeps reference with its function.
// - Returning to original function restores reference and indicator; one slot only.
// - Works in every function; continuity captures and subtracts its resistance readings.
// - Overrange decided on raw converter count beyond 19999, and with a reference active also on the difference beyond 19999.
// - Capture happens on the next measurement cycle, up to about 1.4 s away.
`ifndef RRO_MAP_VH
`define RRO_MAP_VH

// Datapath widths
`define RRO_VAL_W 20
`define RRO_EXT_W 40
`define RRO_FUNC_W 4
`define RRO_RANGE_W 3
`define RRO_STEPS 7

// Converter full scale in counts
`define RRO_MAX_COUNT 40'sh0000004E1F
`define RRO_ZERO_VAL 20'h00000

// Function codes that need special handling
`define RRO_FUNC_RES 4'h4
`define RRO_FUNC_CONT 4'h9

// Scaling step operations
`define RRO_OP_PASS 2'h0
`define RRO_OP_MUL 2'h1
`define RRO_OP_DIV 2'h2
`define RRO_TEN 40'sh000000000A

// Timing: longest measurement cadence
`define RRO_CLK_KHZ 50000
`define RRO_SLOW_MS 1400
`define RRO_CNT_W 32

// Register byte offsets (address bits 7:0)
`define RRO_ADDR_CTRL 8'h00
`define RRO_ADDR_STATUS 8'h04
`define RRO_ADDR_REF 8'h08
`define RRO_ADDR_RESULT 8'h0C

// CTRL fields
`define RRO_CTRL_KEY 0
`define RRO_CTRL_CLR 1
`define RRO_CTRL_KEN 2
`define RRO_CTRL_KEN_RST 1'b1

// STATUS fields
`define RRO_ST_IND 0
`define RRO_ST_PEND 1
`define RRO_ST_VALID 2
`define RRO_ST_LATE 3
`define RRO_ST_OVER 4
`define RRO_ST_FUNC_LO 8
`define RRO_ST_FUNC_HI 11
`define RRO_ST_RANGE_LO 12
`define RRO_ST_RANGE_HI 14

// AHB-Lite encodings
`define RRO_HTRANS_ACT 1
`define RRO_HRESP_OKAY 1'b0
`define RRO_WORD_ZERO 32'h00000000

`endif

// [logic/rro_step10.v]
// One power-of-ten step of the reference rescaler
`timescale 1ns/100ps
`include "rro_map.vh"

module rro_step10 (
  input wire [1:0] op,
  input wire signed [`RRO_EXT_W-1:0] din,
  output reg signed [`RRO_EXT_W-1:0] dout
);

  // Multiply, divide (truncating toward zero) or pass
  always @* begin
    case (op)
      `RRO_OP_MUL: dout = din * `RRO_TEN;
      `RRO_OP_DIV: dout = din / `RRO_TEN;
      default: dout = din;
    endcase
  end

endmodule

// [logic/rro_top.v]
// Relative-reference offset unit with AHB-Lite register slave
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`include "rro_map.vh"

module rro_top #(
  parameter LATE_CYCLES = `RRO_SLOW_MS * `RRO_CLK_KHZ
) (
  input wire MCLK,
  input wire RSTN,
  input wire OFFSET_NULL_KEY,
  input wire [`RRO_FUNC_W-1:0] FUNC_SEL,
  input wire [`RRO_RANGE_W-1:0] RANGE_SEL,
  input wire MEAS_VALID,
  input wire signed [`RRO_VAL_W-1:0] MEAS_COUNT,
  output reg REL_IND,
  output reg DISP_VALID,
  output reg signed [`RRO_VAL_W-1:0] DISP_VALUE,
  output reg DISP_OVER,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP
);

  // Key pin synchroniser and edge detector
  reg key_s1;
  reg key_s2;
  reg key_s3;

  // Reference slot and control state
  reg ref_valid;
  reg signed [`RRO_VAL_W-1:0] ref_val;
  reg [`RRO_FUNC_W-1:0] ref_func;
  reg [`RRO_RANGE_W-1:0] ref_range;
  reg pending;
  reg late;
  reg [`RRO_CNT_W-1:0] late_cnt;
  reg [`RRO_FUNC_W-1:0] prev_func;

  // Register-side state
  reg key_en;
  reg sw_key;
  reg sw_clr;
  reg wr_pend;
  reg [7:0] wr_addr;

  // Combinational datapath
  reg [`RRO_FUNC_W-1:0] eff_func;
  reg signed [`RRO_RANGE_W:0] range_diff;
  reg [`RRO_RANGE_W:0] steps;
  reg [1:0] step_op;
  reg signed [`RRO_EXT_W-1:0] meas_ext;
  reg signed [`RRO_EXT_W-1:0] diff;
  reg raw_over;
  reg diff_over;
  reg func_match;
  reg key_evt;
  reg [31:0] next_rdata;
  wire signed [`RRO_EXT_W-1:0] scale_chain [0:`RRO_STEPS];
  wire ahb_go;

  assign ahb_go = HSEL & HTRANS[`RRO_HTRANS_ACT] & HREADY;

  // Two flops before the key is looked at, then a third for the edge
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      key_s1 <= 1'b0;
      key_s2 <= 1'b0;
      key_s3 <= 1'b0;
    end else begin
      key_s1 <= OFFSET_NULL_KEY;
      key_s2 <= key_s1;
      key_s3 <= key_s2;
    end
  end

  // Key event from the pin (when enabled) or from a software write
  always @* begin
    key_evt = (key_s2 & ~key_s3 & key_en) | sw_key;
  end

  // Continuity readings are resistance readings, so they share its tag
  always @* begin
    if (FUNC_SEL == `RRO_FUNC_CONT) begin
      eff_func = `RRO_FUNC_RES;
    end else begin
      eff_func = FUNC_SEL;
    end
    func_match = ref_valid && (eff_func == ref_func);
  end

  // Range step between now and capture picks direction and count of steps
  always @* begin
    range_diff = $signed({1'b0, RANGE_SEL}) - $signed({1'b0, ref_range});
    if (range_diff > 0) begin
      steps = range_diff;
      step_op = `RRO_OP_DIV;
    end else begin
      steps = -range_diff;
      step_op = `RRO_OP_MUL;
    end
  end

  assign scale_chain[0] = {{(`RRO_EXT_W-`RRO_VAL_W){ref_val[`RRO_VAL_W-1]}}, ref_val};

  // Rescale the stored reference by the power of ten of the range step
  genvar gi;
  generate
    for (gi = 0; gi < `RRO_STEPS; gi = gi + 1) begin : g_scale
      rro_step10 u_step (
        .op((gi < steps) ? step_op : `RRO_OP_PASS),
        .din(scale_chain[gi]),
        .dout(scale_chain[gi+1])
      );
    end
  endgenerate

  // Signed difference and overrange decisions
  always @* begin
    meas_ext = {{(`RRO_EXT_W-`RRO_VAL_W){MEAS_COUNT[`RRO_VAL_W-1]}}, MEAS_COUNT};
    diff = meas_ext - scale_chain[`RRO_STEPS];
    raw_over = (meas_ext > `RRO_MAX_COUNT) || (meas_ext < -`RRO_MAX_COUNT);
    diff_over = (diff > `RRO_MAX_COUNT) || (diff < -`RRO_MAX_COUNT);
  end

  // Reference slot, capture and indicator
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ref_valid <= 1'b0;
      ref_val <= `RRO_ZERO_VAL;
      ref_func <= {`RRO_FUNC_W{1'b0}};
      ref_range <= {`RRO_RANGE_W{1'b0}};
      pending <= 1'b0;
      REL_IND <= 1'b0;
      prev_func <= {`RRO_FUNC_W{1'b0}};
      DISP_VALID <= 1'b0;
      DISP_VALUE <= `RRO_ZERO_VAL;
      DISP_OVER <= 1'b0;
    end else begin
      prev_func <= eff_func;
      DISP_VALID <= MEAS_VALID;
      // A completed measurement: capture it or show it
      if (MEAS_VALID) begin
        DISP_OVER <= raw_over;
        if (pending && !key_evt) begin
          ref_val <= MEAS_COUNT;
          ref_func <= eff_func;
          ref_range <= RANGE_SEL;
          ref_valid <= 1'b1;
          pending <= 1'b0;
          DISP_VALUE <= `RRO_ZERO_VAL;
        end else if (func_match) begin
          DISP_VALUE <= diff[`RRO_VAL_W-1:0];
          DISP_OVER <= raw_over | diff_over;
        end else begin
          DISP_VALUE <= MEAS_COUNT;
        end
      end
      // Indicator follows the slot whenever no capture is waiting
      if (!pending) begin
        REL_IND <= func_match;
      end
      // Leaving the function while waiting abandons the capture
      if (pending && (eff_func != prev_func)) begin
        pending <= 1'b0;
        REL_IND <= 1'b0;
      end
      // Key press: cancel a waiting capture, cancel the reference, or arm
      if (key_evt) begin
        if (pending) begin
          pending <= 1'b0;
          REL_IND <= 1'b0;
        end else if (REL_IND) begin
          ref_valid <= 1'b0;
          REL_IND <= 1'b0;
        end else begin
          pending <= 1'b1;
          REL_IND <= 1'b1;
        end
      end
      // Software clear stands for power removal
      if (sw_clr) begin
        ref_valid <= 1'b0;
        pending <= 1'b0;
        REL_IND <= 1'b0;
      end
    end
  end

  // Flags a capture still waiting after the slowest measurement cadence
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      late_cnt <= {`RRO_CNT_W{1'b0}};
      late <= 1'b0;
    end else if (!pending) begin
      late_cnt <= {`RRO_CNT_W{1'b0}};
      late <= 1'b0;
    end else if (late_cnt >= LATE_CYCLES) begin
      late <= 1'b1;
    end else begin
      late_cnt <= late_cnt + 1'b1;
    end
  end

  // Read data mux, sampled in the address phase
  always @* begin
    next_rdata = `RRO_WORD_ZERO;
    case (HADDR[7:0])
      `RRO_ADDR_CTRL: begin
        next_rdata[`RRO_CTRL_KEN] = key_en;
      end
      `RRO_ADDR_STATUS: begin
        next_rdata[`RRO_ST_IND] = REL_IND;
        next_rdata[`RRO_ST_PEND] = pending;
        next_rdata[`RRO_ST_VALID] = ref_valid;
        next_rdata[`RRO_ST_LATE] = late;
        next_rdata[`RRO_ST_OVER] = DISP_OVER;
        next_rdata[`RRO_ST_FUNC_HI:`RRO_ST_FUNC_LO] = ref_func;
        next_rdata[`RRO_ST_RANGE_HI:`RRO_ST_RANGE_LO] = ref_range;
      end
      `RRO_ADDR_REF: begin
        next_rdata = {{(32-`RRO_VAL_W){ref_val[`RRO_VAL_W-1]}}, ref_val};
      end
      `RRO_ADDR_RESULT: begin
        next_rdata = {{(32-`RRO_VAL_W){DISP_VALUE[`RRO_VAL_W-1]}}, DISP_VALUE};
      end
      default: begin
        next_rdata = `RRO_WORD_ZERO;
      end
    endcase
    if (HADDR[31:8] != 24'h000000) begin
      next_rdata = `RRO_WORD_ZERO;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      HRDATA <= `RRO_WORD_ZERO;
      HREADYOUT <= 1'b1;
      HRESP <= `RRO_HRESP_OKAY;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      key_en <= `RRO_CTRL_KEN_RST;
      sw_key <= 1'b0;
      sw_clr <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= `RRO_HRESP_OKAY;
      sw_key <= 1'b0;
      sw_clr <= 1'b0;
      // Data phase of a write lands in CTRL
      if (wr_pend && (wr_addr == `RRO_ADDR_CTRL)) begin
        sw_key <= HWDATA[`RRO_CTRL_KEY];
        sw_clr <= HWDATA[`RRO_CTRL_CLR];
        key_en <= HWDATA[`RRO_CTRL_KEN];
      end
      // Address phase
      wr_pend <= ahb_go & HWRITE & (HADDR[31:8] == 24'h000000);
      wr_addr <= HADDR[7:0];
      if (ahb_go && !HWRITE) begin
        HRDATA <= next_rdata;
      end
    end
  end

endmodule

// [tb/rro_adc_model.sv]
// Converter model: one strobe and count per measurement
`timescale 1ns/100ps
`include "rro_map.vh"
module rro_adc_model (
  input wire clk,
  output logic meas_valid,
  output logic signed [`RRO_VAL_W-1:0] meas_count
);
  // Idle before the first conversion
  initial begin
    meas_valid = 1'b0;
    meas_count = '0;
  end
  // One completed conversion after gap idle cycles
  task automatic convert(input logic signed [`RRO_VAL_W-1:0] cnt, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_count <= cnt;
    @(posedge clk);
    meas_valid <= 1'b0;
    meas_count <= ~cnt; // Count not held after the strobe
  endtask
endmodule

// [tb/rro_top_asserts.sv]
// Port assertions of the offset unit
`timescale 1ns/100ps
`include "rro_map.vh"
module rro_chk (
  input wire MCLK,
  input wire RSTN,
  input wire OFFSET_NULL_KEY,
  input wire [`RRO_FUNC_W-1:0] FUNC_SEL,
  input wire MEAS_VALID,
  input wire signed [`RRO_VAL_W-1:0] MEAS_COUNT,
  input wire REL_IND,
  input wire DISP_VALID,
  input wire signed [`RRO_VAL_W-1:0] DISP_VALUE,
  input wire DISP_OVER
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);
  // Raw count beyond converter full scale
  wire big = MEAS_COUNT > 19999 || MEAS_COUNT < -19999;
  property p_strobe; MEAS_VALID |=> DISP_VALID; endproperty
  a_strobe: assert property (p_strobe) else $error("no strobe");
  property p_quiet; !MEAS_VALID |=> !DISP_VALID; endproperty
  a_quiet: assert property (p_quiet) else $error("stray strobe");
  property p_hold; !MEAS_VALID |=> $stable(DISP_VALUE) && $stable(DISP_OVER); endproperty
  a_hold: assert property (p_hold) else $error("display moved");
  property p_over; MEAS_VALID && big |=> DISP_OVER; endproperty
  a_over: assert property (p_over) else $error("overrange missed");
  property p_fit; MEAS_VALID && !big && !REL_IND |=> !DISP_OVER; endproperty
  a_fit: assert property (p_fit) else $error("false overrange");
  property p_set; $rose(OFFSET_NULL_KEY) && !REL_IND |-> ##[1:5] REL_IND; endproperty
  a_set: assert property (p_set) else $error("indicator late");
  property p_drop; $rose(OFFSET_NULL_KEY) && REL_IND |-> ##[1:5] !REL_IND; endproperty
  a_drop: assert property (p_drop) else $error("indicator kept");
  property p_func;
    REL_IND && $changed(FUNC_SEL) && FUNC_SEL != `RRO_FUNC_CONT && $past(FUNC_SEL) != `RRO_FUNC_CONT
      |-> ##[1:2] !REL_IND;
  endproperty
  a_func: assert property (p_func) else $error("indicator kept");
  c_set: cover property ($rose(REL_IND));
  c_drop: cover property ($fell(REL_IND));
  c_over: cover property (DISP_VALID && DISP_OVER);
endmodule
bind rro_top rro_chk chk_u (.MCLK(MCLK), .RSTN(RSTN), .OFFSET_NULL_KEY(OFFSET_NULL_KEY), .FUNC_SEL(FUNC_SEL),
  .MEAS_VALID(MEAS_VALID), .MEAS_COUNT(MEAS_COUNT), .REL_IND(REL_IND), .DISP_VALID(DISP_VALID),
  .DISP_VALUE(DISP_VALUE), .DISP_OVER(DISP_OVER));

// [tb/tb_top.sv]
// Self-checking bench of the offset unit
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_n, key, hsel, hwrite, offset_null_key, dv, dov, hrdy, hresp, mv;
  logic [3:0] func;
  logic [2:0] rng, hsize;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic signed [19:0] mc, dval;
  int err_count, tests_run;
  rro_adc_model adc_u (.clk(clk), .meas_valid(mv), .meas_count(mc));
  rro_top #(.LATE_CYCLES(50)) dut_u (.MCLK(clk), .RSTN(rst_n), .OFFSET_NULL_KEY(key), .FUNC_SEL(func),
    .RANGE_SEL(rng), .MEAS_VALID(mv), .MEAS_COUNT(mc), .REL_IND(offset_null_key), .DISP_VALID(dv), .DISP_VALUE(dval),
    .DISP_OVER(dov), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp));
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Single word transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= a;
    // Address phase held until ready is seen high
    @(posedge clk);
    while (hrdy !== 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    // Data phase held until ready is seen high again
    @(posedge clk);
    while (hrdy !== 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
    end
    q = hrdata;
    chk("response", 32'(hresp), 32'h0);
    if (n >= 40) begin
      err_count++;
      wrap_up();
    end
  endtask
  // One conversion, then the displayed result and indicator
  task automatic meas(input int c, input int e, input logic o, r);
    adc_u.convert(20'(c), tests_run % 3);
    #1;
    chk("strobe", 32'(dv), 32'h1);
    chk("value", 32'(dval), e);
    chk("over", 32'(dov), 32'(o));
    chk("indicator", 32'(offset_null_key), 32'(r));
  endtask
  task automatic press;
    @(posedge clk);
    key <= 1'b1;
    repeat (6) @(posedge clk);
    key <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic sel(input logic [3:0] f, input logic [2:0] r);
    @(posedge clk);
    func <= f;
    rng <= r;
    repeat (3) @(posedge clk);
  endtask
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Main sequence
  initial begin
    {rst_n, key, hsel, hwrite} = 4'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    func = 4'h1;
    rng = 3'h2;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 32'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    meas(100, 100, 0, 0);
    press();
    chk("indicator", 32'(offset_null_key), 32'h1);
    bus(1'b0, 32'h4, 32'h0);
    chk("pending", q & 32'h3, 32'h3);
    meas(10000, 0, 0, 1);
    bus(1'b0, 32'h4, 32'h0);
    chk("status", q & 32'h7F17, 32'h2105);
    bus(1'b0, 32'h8, 32'h0);
    chk("reference", q, 10000);
    meas(12700, 2700, 0, 1);
    bus(1'b0, 32'hC, 32'h0);
    chk("result", q, 32'(2700));
    meas(8500, -1500, 0, 1);
    meas(20000, 10000, 1, 1);
    sel(4'h1, 3'h3);
    meas(1200, 200, 0, 1);
    sel(4'h1, 3'h1);
    meas(19000, -81000, 1, 1);
    sel(4'h4, 3'h1);
    meas(300, 300, 0, 0);
    sel(4'h1, 3'h2);
    meas(10500, 500, 0, 1);
    press();
    meas(700, 700, 0, 0);
    press();
    press();
    meas(900, 900, 0, 0);
    press();
    meas(1000, 0, 0, 1);
    sel(4'h9, 3'h2); // Fixed resistance range only
    press();
    meas(50, 0, 0, 1);
    meas(80, 30, 0, 1);
    sel(4'h1, 3'h2);
    meas(1500, 1500, 0, 0);
    bus(1'b1, 32'h0, 32'h5);
    meas(400, 0, 0, 1);
    // Power removal: a mid-run reset drops the slot and the indicator
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("indicator", 32'(offset_null_key), 32'h0);
    bus(1'b0, 32'h4, 32'h0);
    chk("status", q & 32'h7, 32'h0);
    // A capture left waiting past the slowest cadence is flagged late
    press();
    repeat (60) @(posedge clk);
    bus(1'b0, 32'h4, 32'h0);
    chk("late", q & 32'hF, 32'hB);
    // Software clear drops the waiting capture and the indicator
    bus(1'b1, 32'h0, 32'h6);
    bus(1'b0, 32'h4, 32'h0);
    chk("cleared", q & 32'h7, 32'h0);
    bus(1'b0, 32'h0, 32'h0);
    chk("key enable", q, 32'h4);
    wrap_up();
  end
endmodule
